// File: rtl/seq_pkg.sv
package seq_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [4:0] OFF_BUCK_CTRL = 5'h00;
    localparam logic [4:0] OFF_BB_CTRL   = 5'h04;
    localparam logic [4:0] OFF_LDO_ON    = 5'h08;
    localparam logic [4:0] OFF_LDO_LP    = 5'h0C;
    localparam logic [4:0] OFF_STATUS    = 5'h10;
    localparam logic [4:0] OFF_IRQ_FLAGS = 5'h14;
    localparam logic [4:0] OFF_IRQ_MASK  = 5'h18;

    // ==========================================================
    // Field positions
    localparam int BIT_ON       = 0;
    localparam int BIT_LP       = 1;
    localparam int BIT_WARN_LO  = 0;
    localparam int BIT_WARN_HI  = 1;
    localparam int LDO12_IDX    = 11;
    localparam int NUM_LDO      = 15;

    // ==========================================================
    // Reset values
    localparam logic [1:0]  RST_BUCK = 2'h0;
    localparam logic        RST_BB   = 1'h0;
    localparam logic [14:0] RST_LDO  = 15'h0000;
    localparam logic [1:0]  RST_IRQ  = 2'h0;
    localparam logic [1:0]  RST_MASK = 2'h0;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ        = 10;
    localparam int BIAS_SETTLE_US = 85;
    localparam int REF_SETTLE_US  = 85;
    localparam int BIAS_CYC       = BIAS_SETTLE_US * CLK_MHZ;
    localparam int REF_CYC        = REF_SETTLE_US * CLK_MHZ;
    localparam int SETTLE_W       = 12;

    // ==========================================================
    // Top-level power states
    typedef enum logic [3:0] {
        ST_OFF     = 4'h1,
        ST_UVLO    = 4'h2,
        ST_THERMAL = 4'h4,
        ST_STANDBY = 4'h8
    } pwr_state_t;
endpackage

// File: rtl/pmic_sequencer.sv
// How it works
// - Die overtemperature forces global shutdown state.
// - Each unmasked warning comparator trip raises interrupt.
// - Thermal shutdown holds until hysteresis release.
// - Local thermal trip disables only that regulator.
// - Supply undervoltage locks out, ignores bus, resets.
// - Lockout exits only on rising supply comparator.
// - Chip enable high gives standby, registers reachable.
// - Bias starts at enable; buck-boost starts on request, no settle wait.
// - Early enable still starts, slow startup flagged.
// - Chip enable low turns all off, resets.
// - Thermal, supply or IO fault shuts down immediately.
// - After thermal shutdown, enable refused until cool.
// - Every regulator has mode bits, on resets 0.
// - Pin or bit turns buck, buck-boost, ldo12 on.
// - Buck and ldo12 low-power from low-power bit.
// - Buck-boost always runs normal mode.
// - Other linear regulators controlled only by bits.
// - Supply below reset level resets system-class registers.
// - Any power-off event restores off-class registers.
// - Serial pins released while device off.
// - Interrupt pin low while unmasked interrupt pending.
// - Serial-only regulator off, low-power, or normal.
module pmic_sequencer
    import seq_pkg::*;
#(
    parameter int BIAS_CYCLES = BIAS_CYC,
    parameter int REF_CYCLES  = REF_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Pins from the host
    input  wire logic        chip_enable_pin,
    input  wire logic        buck_enable_pin,
    input  wire logic        buckboost_enable_pin,
    input  wire logic        ldo12_enable_pin,
    // Analog comparators
    input  wire logic        thermal_trip_threshold,
    input  wire logic        thermal_release,
    input  wire logic        warn_low_trip,
    input  wire logic        warn_high_trip,
    input  wire logic        sys_falling_trip,
    input  wire logic        sys_rising_ok,
    input  wire logic        sys_por_trip,
    input  wire logic        vio_ok,
    input  wire logic [15:0] local_thermal_trip,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Regulator controls
    output logic             buck_on,
    output logic             buck_lowpower,
    output logic             buckboost_on,
    output logic      [14:0] ldo_on,
    output logic      [14:0] ldo_lowpower,
    output logic             bias_enable,
    output logic             bias_ready,
    output logic             reference_ready,
    output logic             slow_start,
    output logic             serial_bus_enable,
    output logic             interrupt_n_pin
);

    // ==========================================================
    // Input synchronisers
    localparam int NSYNC = 28;

    logic [NSYNC-1:0] async_in;     // Raw pins and comparators
    logic [NSYNC-1:0] meta_reg;     // First stage, read by stage two only
    logic [NSYNC-1:0] sync_reg;     // Second stage, safe to use

    assign async_in = {local_thermal_trip, vio_ok, sys_por_trip,
                       sys_rising_ok, sys_falling_trip, warn_high_trip,
                       warn_low_trip, thermal_release, thermal_trip_threshold,
                       ldo12_enable_pin, buckboost_enable_pin,
                       buck_enable_pin, chip_enable_pin};

    // Two flops on every outside level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    logic        ce_s;          // Chip enable
    logic        en_buck_s;     // Buck pin
    logic        en_bb_s;       // Buck-boost pin
    logic        en_l12_s;      // Ldo12 pin
    logic        hot_s;         // Over shutdown temperature
    logic        cool_s;        // Below release temperature
    logic        warn_lo_s;     // Lower warning
    logic        warn_hi_s;     // Upper warning
    logic        sys_low_s;     // Supply below falling trip
    logic        sys_ok_s;      // Supply above rising trip
    logic        por_s;         // Supply below reset level
    logic        vio_s;         // IO supply valid
    logic [15:0] local_s;       // Bit 0 buck-boost, 1..15 ldos

    assign ce_s      = sync_reg[0];
    assign en_buck_s = sync_reg[1];
    assign en_bb_s   = sync_reg[2];
    assign en_l12_s  = sync_reg[3];
    assign hot_s     = sync_reg[4];
    assign cool_s    = sync_reg[5];
    assign warn_lo_s = sync_reg[6];
    assign warn_hi_s = sync_reg[7];
    assign sys_low_s = sync_reg[8];
    assign sys_ok_s  = sync_reg[9];
    assign por_s     = sync_reg[10];
    assign vio_s     = sync_reg[11];
    assign local_s   = sync_reg[27:12];

    // System reset covers both the pin and the supply monitor
    logic sys_rst;
    assign sys_rst = !rst_b || por_s;

    // ==========================================================
    // Power state machine
    pwr_state_t state_reg;
    pwr_state_t state_next;

    // Faults ranked: undervoltage, then thermal, then enable
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_UVLO: begin
                if (sys_ok_s && !sys_low_s)
                    state_next = ST_OFF;
            end
            ST_THERMAL: begin
                if (sys_low_s)
                    state_next = ST_UVLO;
                else if (cool_s && !hot_s)
                    state_next = ST_OFF;
            end
            ST_OFF: begin
                if (sys_low_s)
                    state_next = ST_UVLO;
                else if (hot_s)
                    state_next = ST_THERMAL;
                else if (ce_s && vio_s)
                    state_next = ST_STANDBY;
            end
            ST_STANDBY: begin
                if (sys_low_s)
                    state_next = ST_UVLO;
                else if (hot_s)
                    state_next = ST_THERMAL;
                else if (!ce_s || !vio_s)
                    state_next = ST_OFF;
            end
            default: state_next = ST_OFF;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst)
            state_reg <= ST_OFF;
        else
            state_reg <= state_next;
    end

    logic active;       // Standby this cycle
    logic off_reset;    // Any power-off condition
    assign active    = (state_reg == ST_STANDBY);
    assign off_reset = sys_rst || !active;

    // ==========================================================
    // Bias and reference settling counter
    localparam logic [SETTLE_W-1:0] BIAS_END = SETTLE_W'(BIAS_CYCLES);
    localparam logic [SETTLE_W-1:0] REF_END  = SETTLE_W'(BIAS_CYCLES + REF_CYCLES);

    logic [SETTLE_W-1:0] settle_reg;   // Cycles since enable

    // Restart on every power-off, saturate when reference is ready
    always_ff @(posedge clk) begin
        if (off_reset)
            settle_reg <= '0;
        else if (settle_reg != REF_END)
            settle_reg <= settle_reg + 1'b1;
    end

    logic bias_ok;
    logic ref_ok;
    assign bias_ok = active && (settle_reg >= BIAS_END);
    assign ref_ok  = active && (settle_reg == REF_END);

    // ==========================================================
    // Bus decode
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    logic req;          // Request seen on the cycle waitrequest is low
    logic wr_ok;        // Write accepted this cycle
    logic rd_flags;     // Read of the interrupt flags

    // Requests take effect on the cycle waitrequest is low
    assign req      = (read || write) && !waitrequest;
    // Lockout and shutdown ignore the bus
    assign wr_ok    = req && write && active;
    assign rd_flags = req && read && active && hit(address, OFF_IRQ_FLAGS);

    // ==========================================================
    // Off-class control registers
    logic [1:0]  buck_ctrl_reg;    // Low-power, on
    logic        bb_on_reg;        // Buck-boost on bit
    logic [14:0] ldo_on_reg;       // One on bit per ldo
    logic [14:0] ldo_lp_reg;       // One low-power bit per ldo

    // Mode bits clear on every power-off
    always_ff @(posedge clk) begin
        if (off_reset) begin
            buck_ctrl_reg <= RST_BUCK;
            bb_on_reg     <= RST_BB;
            ldo_on_reg    <= RST_LDO;
            ldo_lp_reg    <= RST_LDO;
        end else if (wr_ok) begin
            if (hit(address, OFF_BUCK_CTRL))
                buck_ctrl_reg <= writedata[1:0];
            else if (hit(address, OFF_BB_CTRL))
                bb_on_reg <= writedata[BIT_ON];
            else if (hit(address, OFF_LDO_ON))
                ldo_on_reg <= writedata[14:0];
            else if (hit(address, OFF_LDO_LP))
                ldo_lp_reg <= writedata[14:0];
        end
    end

    // System-class mask survives power-off, cleared by supply reset
    logic [1:0] mask_reg;

    always_ff @(posedge clk) begin
        if (sys_rst)
            mask_reg <= RST_MASK;
        else if (wr_ok && hit(address, OFF_IRQ_MASK))
            mask_reg <= writedata[1:0];
    end

    // ==========================================================
    // Warning interrupts
    logic       warn_lo_d_reg;   // Previous warning levels
    logic       warn_hi_d_reg;
    logic [1:0] flags_reg;       // Sticky pending events
    logic [1:0] flags_next;
    logic [1:0] rise;

    // Edge detect runs on the second synchroniser stage only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            warn_lo_d_reg <= 1'b0;
            warn_hi_d_reg <= 1'b0;
        end else begin
            warn_lo_d_reg <= warn_lo_s;
            warn_hi_d_reg <= warn_hi_s;
        end
    end

    assign rise[BIT_WARN_LO] = warn_lo_s && !warn_lo_d_reg;
    assign rise[BIT_WARN_HI] = warn_hi_s && !warn_hi_d_reg;

    // Read clears, but a new event in the same cycle survives
    always_comb begin
        flags_next = flags_reg;
        if (rd_flags)
            flags_next = RST_IRQ;
        flags_next = flags_next | (rise & ~mask_reg);
        if (off_reset)
            flags_next = RST_IRQ;
    end

    always_ff @(posedge clk) begin
        flags_reg <= flags_next;
    end

    // Pin low while anything pending
    always_ff @(posedge clk) begin
        if (sys_rst)
            interrupt_n_pin <= 1'b1;
        else
            interrupt_n_pin <= ~|flags_next;
    end

    // ==========================================================
    // Regulator enable logic
    logic [14:0] ldo_req;    // Requested on per ldo
    logic        buck_req;
    logic        bb_req;

    // Pin or bit for the three pin-controlled rails
    assign buck_req = en_buck_s || buck_ctrl_reg[BIT_ON];
    assign bb_req   = en_bb_s || bb_on_reg;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LDO; gi++) begin : g_ldo
            if (gi == LDO12_IDX) begin : g_pin
                assign ldo_req[gi] = ldo_on_reg[gi] || en_l12_s;
            end else begin : g_bit
                assign ldo_req[gi] = ldo_on_reg[gi];
            end
        end
    endgenerate

    // Outputs gated by standby and by each local thermal trip
    always_ff @(posedge clk) begin
        if (off_reset) begin
            buck_on       <= 1'b0;
            buck_lowpower <= 1'b0;
            buckboost_on  <= 1'b0;
            ldo_on        <= '0;
            ldo_lowpower  <= '0;
        end else begin
            buck_on       <= buck_req;
            buck_lowpower <= buck_req && buck_ctrl_reg[BIT_LP];
            buckboost_on  <= bb_req && !local_s[0];
            ldo_on        <= ldo_req & ~local_s[15:1];
            ldo_lowpower  <= ldo_req & ~local_s[15:1] & ldo_lp_reg;
        end
    end

    // ==========================================================
    // Bias status and slow start
    always_ff @(posedge clk) begin
        if (off_reset) begin
            bias_enable     <= 1'b0;
            bias_ready      <= 1'b0;
            reference_ready <= 1'b0;
            slow_start      <= 1'b0;
        end else begin
            bias_enable     <= 1'b1;
            bias_ready      <= bias_ok;
            reference_ready <= ref_ok;
            // Rails enabled early still start at once, flagged as slow start
            if (!ref_ok && (buck_req || bb_req || |ldo_req))
                slow_start <= 1'b1;
        end
    end

    // Serial pins float outside standby
    always_ff @(posedge clk) begin
        if (sys_rst)
            serial_bus_enable <= 1'b0;
        else
            serial_bus_enable <= (state_next == ST_STANDBY);
    end

    // ==========================================================
    // Avalon slave: one wait cycle, then answer
    logic [31:0] status_word;

    assign status_word = {24'h000000, slow_start, ref_ok, bias_ok,
                          hot_s, state_reg};

    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk) begin
        if (!rst_b)
            waitrequest <= 1'b1;
        else if ((read || write) && waitrequest)
            waitrequest <= 1'b0;
        else
            waitrequest <= 1'b1;
    end

    // Read data is loaded with the wait cycle, zero when off
    always_ff @(posedge clk) begin
        if (!rst_b || !active) begin
            readdata <= 32'h00000000;
        end else if (read && waitrequest) begin
            if (hit(address, OFF_BUCK_CTRL))
                readdata <= {30'h00000000, buck_ctrl_reg};
            else if (hit(address, OFF_BB_CTRL))
                readdata <= {31'h00000000, bb_on_reg};
            else if (hit(address, OFF_LDO_ON))
                readdata <= {17'h00000, ldo_on_reg};
            else if (hit(address, OFF_LDO_LP))
                readdata <= {17'h00000, ldo_lp_reg};
            else if (hit(address, OFF_STATUS))
                readdata <= status_word;
            else if (hit(address, OFF_IRQ_FLAGS))
                readdata <= {30'h00000000, flags_reg};
            else if (hit(address, OFF_IRQ_MASK))
                readdata <= {30'h00000000, mask_reg};
            else
                readdata <= 32'h00000000;      // Unmapped reads zero
        end
    end

endmodule

// File: verif/seq_props.sv
// ==========================================
// Sequencer port checks
module seq_props #(
    parameter int BIAS_CYCLES = 8,
    parameter int REF_CYCLES  = 8
) (
    input logic        clk,
    input logic        rst_b,
    input logic        chip_enable_pin,
    input logic        buck_enable_pin,
    input logic        thermal_trip_threshold,
    input logic        thermal_release,
    input logic        sys_falling_trip,
    input logic        vio_ok,
    input logic [15:0] local_thermal_trip,
    input logic        read,
    input logic        write,
    input logic        waitrequest,
    input logic        buck_on,
    input logic        buckboost_on,
    input logic [14:0] ldo_on,
    input logic        bias_enable,
    input logic        bias_ready,
    input logic        reference_ready,
    input logic        serial_bus_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rails_off;  // Rails dark, bus released
    logic hot_seen;   // Trip seen, release not yet
    int   bias_cnt;   // Cycles spent settling bias
    int   ref_cnt;    // Cycles spent settling reference

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    assign rails_off = !buck_on && !buckboost_on && ldo_on == 15'h0000 && !serial_bus_enable;

    // ==========================================
    // Helper state
    // Thermal memory; release alone ends it
    always_ff @(posedge clk) begin
        if (!rst_b || thermal_release) hot_seen <= 1'b0;
        else if (thermal_trip_threshold) hot_seen <= 1'b1;
    end
    // Settle counters; restart whenever bias drops
    always_ff @(posedge clk) begin
        if (!rst_b || !bias_enable) bias_cnt <= 0;
        else if (!bias_ready) bias_cnt <= bias_cnt + 1;
    end
    always_ff @(posedge clk) begin
        if (!rst_b || !bias_ready) ref_cnt <= 0;
        else if (!reference_ready) ref_cnt <= ref_cnt + 1;
    end

    // ==========================================
    // Assertions; five samples cover the sync latency
    ce_low_off_a: assert property (
        !chip_enable_pin [*5] |-> rails_off)
        else $error("alive with chip enable low");
    hot_hold_a: assert property (
        hot_seen [*5] |-> rails_off)
        else $error("alive while hot");
    uvlo_off_a: assert property (
        sys_falling_trip [*5] |-> rails_off)
        else $error("alive in lockout");
    vio_off_a: assert property (
        !vio_ok [*5] |-> rails_off)
        else $error("alive without io supply");
    wait_once_a: assert property (
        $rose(read || write) && waitrequest |=> !waitrequest)
        else $error("no answer after one wait");
    wait_drop_a: assert property (
        !waitrequest |=> waitrequest)
        else $error("answer held too long");
    bias_time_a: assert property (
        $rose(bias_ready) |-> bias_cnt >= BIAS_CYCLES && bias_cnt <= BIAS_CYCLES + 1)
        else $error("bias settle time wrong");
    ref_time_a: assert property (
        $rose(reference_ready) |-> ref_cnt >= REF_CYCLES && ref_cnt <= REF_CYCLES + 1)
        else $error("reference settle time wrong");
    local_trip_a: assert property (
        $stable(local_thermal_trip) [*4] |->
            (ldo_on & local_thermal_trip[15:1]) == 15'h0000
            && !(buckboost_on && local_thermal_trip[0]))
        else $error("hot rail on");
    pin_on_a: assert property (
        (buck_enable_pin && serial_bus_enable) [*5] |-> buck_on)
        else $error("buck pin ignored");
endmodule

// File: verif/host_model.sv
// ==========================================
// Host side of the register bus
module host_model (
    input  wire logic        clk,
    output logic      [4:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    bit timed_out = 1'b0;  // A transfer went unanswered

    initial {address, read, write, writedata} = '0;

    // One transfer, held until waitrequest is sampled low
    // Call just after an edge; returns one edge after release
    task automatic xfer(input logic is_wr, input logic [4:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !is_wr;
        write <= is_wr;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        q = readdata;
        if (n >= 50) timed_out = 1'b1;
        read <= 1'b0;
        write <= 1'b0;
        // Idle bus shows no stale value
        address <= ~a;
        writedata <= ~d;
        @(posedge clk);
    endtask
endmodule

// File: verif/tb_pmic_sequencer.sv
module tb_pmic_sequencer import seq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // Short settle counts keep the run brief
    localparam int BIAS_CYCLES = 8;
    localparam int REF_CYCLES  = 8;

    logic clk = 1'b0, rst_b = 1'b0;
    logic chip_enable_pin, buck_enable_pin, buckboost_enable_pin, ldo12_enable_pin;
    logic thermal_trip_threshold, thermal_release, warn_low_trip, warn_high_trip;
    logic sys_falling_trip, sys_rising_ok, sys_por_trip, vio_ok;
    logic [15:0] local_thermal_trip;
    logic [4:0]  address;
    logic        read, write, waitrequest;
    logic [31:0] writedata, readdata;
    logic buck_on, buck_lowpower, buckboost_on, bias_enable, bias_ready;
    logic reference_ready, slow_start, serial_bus_enable, interrupt_n_pin;
    logic [14:0] ldo_on, ldo_lowpower, e;
    logic [31:0] rdat, r_buck, r_bb, r_on, r_lp;
    int seed = 32'hE345;
    int err_total = 0;
    int check_count = 0;

    always #50 clk = ~clk;

    pmic_sequencer #(.BIAS_CYCLES(BIAS_CYCLES), .REF_CYCLES(REF_CYCLES)) u_dut (
        .clk, .rst_b, .chip_enable_pin, .buck_enable_pin, .buckboost_enable_pin,
        .ldo12_enable_pin, .thermal_trip_threshold, .thermal_release, .warn_low_trip,
        .warn_high_trip, .sys_falling_trip, .sys_rising_ok, .sys_por_trip, .vio_ok,
        .local_thermal_trip, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .buck_on, .buck_lowpower, .buckboost_on, .ldo_on, .ldo_lowpower, .bias_enable,
        .bias_ready, .reference_ready, .slow_start, .serial_bus_enable, .interrupt_n_pin);
    host_model u_host (.clk, .address, .read, .write, .writedata, .readdata, .waitrequest);

    // ==========================================
    // Shared tasks
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Random idle gap makes the host prompt or slow
    task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
        cyc($unsigned($random(seed)) % 3);
        u_host.xfer(is_wr, a, d, rdat);
        if (u_host.timed_out) begin err_total++; finish_test(); end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(0, a, 32'h0);
        check(rdat, exp);
    endtask
    // Bounded wait on bus enable, reference or interrupt; a miss ends the run
    task automatic wait_hi(input int which, input int limit);
        int n;
        n = 0;
        while ((which == 0 ? serial_bus_enable : which == 1 ? reference_ready
                : !interrupt_n_pin) !== 1'b1 && n < limit) begin
            @(posedge clk);
            n++;
        end
        if (n >= limit) begin err_total++; finish_test(); end
    endtask
    // Stage 0 faulted, 1 half cleared (io fully cleared), 2 cleared
    task automatic set_fault(input int k, input int stage);
        case (k)
            0: begin thermal_trip_threshold <= (stage == 0); thermal_release <= (stage == 2); end
            1: begin sys_falling_trip <= (stage == 0); sys_rising_ok <= (stage == 2); end
            default: vio_ok <= (stage != 0);
        endcase
    endtask
    // Expected ldo enables: bits, ldo12 pin, local trips
    function automatic logic [14:0] exp_ldo(input logic [14:0] b, input logic p,
                                            input logic [15:0] t);
        return (b | (15'(p) << LDO12_IDX)) & ~t[15:1];
    endfunction

    // ==========================================
    // Main sequence
    initial begin
        {chip_enable_pin, buck_enable_pin, buckboost_enable_pin, ldo12_enable_pin} = 4'h0;
        {thermal_trip_threshold, warn_low_trip, warn_high_trip, sys_falling_trip} = 4'h0;
        {thermal_release, sys_rising_ok, vio_ok, sys_por_trip} = 4'hE;
        local_thermal_trip = 16'h0000;
        cyc(8);
        rst_b <= 1'b1;
        cyc(1);
        check(interrupt_n_pin, 1'b1);
        check({serial_bus_enable, buck_on, buckboost_on, ldo_on}, 18'h0);
        // Early rail request gives slow start
        chip_enable_pin <= 1'b1;
        wait_hi(0, 20);
        cyc(2);
        check(bias_enable, 1'b1);
        bus(1, OFF_LDO_ON, 32'h0001);
        wait_hi(1, 100);
        rd_chk(OFF_STATUS, 32'hE8);
        check(slow_start, 1'b1);
        // Random enables, pins and local trips
        for (int i = 0; i < 12; i++) begin
            {buck_enable_pin, buckboost_enable_pin, ldo12_enable_pin} <= 3'($random(seed));
            local_thermal_trip <= (i < 2) ? 16'h0000 : 16'($random(seed)) & 16'h8803;
            r_buck = $random(seed) & 32'h3;
            r_bb = $random(seed) & 32'h1;
            r_on = (i == 11) ? 32'h7FFF : $random(seed) & 32'h7FFF;
            r_lp = $random(seed) & 32'h7FFF;
            bus(1, OFF_BUCK_CTRL, r_buck);
            bus(1, OFF_BB_CTRL, r_bb);
            bus(1, OFF_LDO_ON, r_on);
            bus(1, OFF_LDO_LP, r_lp);
            cyc(4);
            e = exp_ldo(r_on[14:0], ldo12_enable_pin, local_thermal_trip);
            check(buck_on, buck_enable_pin | r_buck[0]);
            if (buck_enable_pin | r_buck[0]) check(buck_lowpower, r_buck[1]);
            check(buckboost_on, (buckboost_enable_pin | r_bb[0]) & ~local_thermal_trip[0]);
            check(ldo_on, e);
            check(ldo_lowpower & e, r_lp[14:0] & e);
            rd_chk(OFF_LDO_LP, r_lp);
        end
        rd_chk(5'h1C, 32'h0);
        // Warning events, unmasked then masked
        local_thermal_trip <= 16'h0000;
        bus(1, OFF_IRQ_MASK, 32'h0);
        for (int b = 0; b < 2; b++) begin
            if (b == 0) warn_low_trip <= 1'b1;
            else warn_high_trip <= 1'b1;
            wait_hi(2, 20);
            rd_chk(OFF_IRQ_FLAGS, 32'(1 << b));
            cyc(2);
            check(interrupt_n_pin, 1'b1);
            {warn_low_trip, warn_high_trip} <= 2'b00;
            cyc(4);
        end
        bus(1, OFF_IRQ_MASK, 32'h2);
        warn_high_trip <= 1'b1;
        cyc(8);
        check(interrupt_n_pin, 1'b1);
        warn_high_trip <= 1'b0;
        // Chip enable low beats the pins
        chip_enable_pin <= 1'b0;
        {buck_enable_pin, buckboost_enable_pin, ldo12_enable_pin} <= 3'b111;
        cyc(6);
        check({slow_start, serial_bus_enable, buck_on, buckboost_on, ldo_on}, '0);
        rd_chk(OFF_STATUS, 32'h0);
        chip_enable_pin <= 1'b1;
        wait_hi(0, 20);
        rd_chk(OFF_LDO_ON, 32'h0);
        rd_chk(OFF_IRQ_MASK, 32'h2);
        sys_por_trip <= 1'b1;
        cyc(6);
        sys_por_trip <= 1'b0;
        wait_hi(0, 20);
        rd_chk(OFF_IRQ_MASK, 32'h0);
        // Thermal, lockout and io faults
        for (int k = 0; k < 3; k++) begin
            bus(1, OFF_LDO_ON, 32'h0001);
            set_fault(k, 0);
            cyc(6);
            check({serial_bus_enable, buck_on, ldo_on}, 17'h0);
            set_fault(k, 1);
            cyc(8);
            check(serial_bus_enable, k == 2);
            set_fault(k, 2);
            wait_hi(0, 20);
            rd_chk(OFF_LDO_ON, 32'h0);
        end
        finish_test();
    end
endmodule

bind pmic_sequencer seq_props #(.BIAS_CYCLES(BIAS_CYCLES), .REF_CYCLES(REF_CYCLES)) u_props (
    .clk, .rst_b, .chip_enable_pin, .buck_enable_pin, .thermal_trip_threshold,
    .thermal_release, .sys_falling_trip, .vio_ok, .local_thermal_trip, .read, .write,
    .waitrequest, .buck_on, .buckboost_on, .ldo_on, .bias_enable, .bias_ready,
    .reference_ready, .serial_bus_enable);
